// File: rtl/mps_pkg.sv
package mps_pkg;

  // Frame and table sizes.
  localparam int FRAME_MAX = 35;
  localparam int N_GROUPS = 10;
  localparam int N_INDEX = 16;
  localparam int N_PARAMS = 160;
  localparam int N_DI_WORDS = 4;
  localparam int N_TERMINALS = 8;
  localparam int READ_MAX = 15;
  localparam int WRITE_MAX = 13;

  // Function codes and the exception flag.
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE1 = 8'h06;
  localparam logic [7:0] FN_WRITEN = 8'h10;
  localparam logic [7:0] FN_ERR_BIT = 8'h80;

  // Exception codes, numbered as the drive reports them (decimal values).
  localparam logic [7:0] E_NONE = 8'h00;
  localparam logic [7:0] E_CMD = 8'h01;
  localparam logic [7:0] E_PARAM = 8'h03;
  localparam logic [7:0] E_CRC = 8'h04;
  localparam logic [7:0] E_GROUP = 8'h10;
  localparam logic [7:0] E_ZERO = 8'h11;
  localparam logic [7:0] E_HALF = 8'h12;
  localparam logic [7:0] E_LIMIT = 8'h13;
  localparam logic [7:0] E_NOPW = 8'h14;
  localparam logic [7:0] E_LOCKED = 8'h15;
  localparam logic [7:0] E_PWMIX = 8'h18;
  localparam logic [7:0] E_PWBAD = 8'h19;
  localparam logic [7:0] E_PWBAD5 = 8'h1a;

  // Address map: group in the high byte, index in the low byte.
  localparam logic [2:0] EEPROM_TAG = 3'b111;
  localparam logic [15:0] ADDR_PASSWORD = 16'h0000;
  localparam logic [15:0] ADDR_DI_STATUS = 16'h3607;
  localparam logic [7:0] LOCKED_GROUP = 8'h01;
  localparam logic [7:0] WIDE_LO_INDEX = 8'h0e;
  localparam logic [7:0] SELECT_GROUP = 8'h04;
  localparam logic [15:0] SELECT_MAX = 16'h0022;
  localparam int SEL_PIDX0 = 65;
  localparam int ENABLE_PIDX0 = 149;
  localparam int TIMEOUT_PIDX = 155;
  localparam logic [15:0] TIMEOUT_RST_MS = 16'h1388;
  localparam logic [15:0] PW_EXPIRE_MS = 16'hea60;
  localparam logic [2:0] PW_FAIL_LIMIT = 3'h5;

  // CRC-16 as used on the link, sent low byte first.
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  // Millisecond tick derived from the 100 MHz clock.
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

  typedef enum logic [4:0] {
    ST_RECV  = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_SCAN  = 5'b00100,
    ST_APPLY = 5'b01000,
    ST_SEND  = 5'b10000
  } mps_state_t;

  typedef struct packed {
    logic eeprom;
    logic is_di;
    logic is_pw;
    logic bad_grp;
    logic bad_idx;
    logic [7:0] pidx;
    logic [1:0] di_word;
    logic [15:0] base;
  } mps_dec_t;

  typedef struct packed {
    logic valid;
    logic eeprom;
    logic [15:0] addr;
    logic [15:0] data;
  } mps_commit_t;

endpackage

// File: rtl/mps_slave.sv
// Summary of operation
// - Register address is group number high byte, index low byte.
// - Without a user password every parameter is readable and writable.
// - Writes to run-locked parameters while running get an error reply.
// - A 32-bit parameter must be accessed as both halves; else code 18.
// - Password writes only check the password; password reads return zero.
// - Writes go to flash copy; address plus E000H also commits to EEPROM.
// - Read 03H: address, function, start, count, CRC; reply carries data.
// - Write 06H carries one register and value; success echoes the frame.
// - Write 10H carries start, count, byte count, data; reply echoes header.
// - Failure reply: address, function plus 80H, code, CRC; 01 and 19.
// - CRC failure gives code 04; non-editable parameter has its own code.
// - Invalid parameter gives 03; protected access without password own code.
// - Group overflowing the parameter groups, or too many registers, gives code 16.
// - Register count zero on read or multi-write gives code 17.
// - Password write mixed with other writes gives code 24.
// - Wrong password gives 25; five wrong in a row gives 26.
// - Eight terminals each select an input function from 1 to 34.
// - Enable word one: bit 0 reserved, bits 1-15 enable functions 1-15.
// - Enable words two to four cover functions 16-31, 32-47, 48-63.
// - Status words: bit 0 reserved, bit n asserts function n onward.
// - Function enabled for link while a terminal selects it raises a fault.
module mps_slave #(
  parameter int MS_CYCLES = mps_pkg::TICK_CYCLES
) (
  input wire logic i_clk,                        // System clock, 100 MHz.
  input wire logic i_rst,                        // Synchronous reset, active high.
  input wire logic [7:0] i_axis_addr,            // Own axis address.
  input wire logic i_rx_valid,                   // Received byte strobe.
  input wire logic [7:0] i_rx_byte,              // Received byte.
  input wire logic i_rx_gap,                     // End of frame (line idle) strobe.
  input wire logic i_tx_ready,                   // Transmitter takes o_tx_byte.
  input wire logic i_drive_running,              // Drive is operating.
  input wire logic [15:0] i_user_password,       // Stored user password, zero is none.
  input wire logic [7:0] i_di_pins,              // Physical input terminals.
  output logic o_tx_valid,                       // Reply byte valid.
  output logic [7:0] o_tx_byte,                  // Reply byte.
  output mps_pkg::mps_commit_t o_commit,         // Parameter write report.
  output logic [63:0] o_di_func,                 // Active input functions.
  output logic o_config_fault,                   // Link and terminal select clash.
  output logic o_pw_unlocked                     // Password entry is valid.
);

  mps_pkg::mps_state_t state_q;
  logic [7:0] rx_buf_q [mps_pkg::FRAME_MAX];
  logic [7:0] tx_buf_q [mps_pkg::FRAME_MAX];
  logic [15:0] prm_q [mps_pkg::N_PARAMS];
  logic [15:0] di_stat_q [mps_pkg::N_DI_WORDS];
  logic [5:0] len_q;
  logic ovf_q;
  logic [15:0] crc_q;
  logic [15:0] tcrc_q;
  logic [5:0] tx_len_q;
  logic [5:0] sidx_q;
  logic [3:0] k_q;
  logic [3:0] n_q;
  logic [2:0] pw_fail_q;
  logic [31:0] tick_q;
  logic [15:0] refresh_ms_q;
  logic [15:0] unlock_ms_q;
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;

  // Byte-wise CRC-16 step, reflected polynomial.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ mps_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Splits a register address into its target; E000H offset marks EEPROM.
  function automatic mps_pkg::mps_dec_t decode(input logic [15:0] a);
    mps_pkg::mps_dec_t d;
    d.eeprom = (a[15:13] == mps_pkg::EEPROM_TAG);
    d.base = d.eeprom ? {3'h0, a[12:0]} : a;
    d.is_di = (d.base >= mps_pkg::ADDR_DI_STATUS) &&
              (d.base < mps_pkg::ADDR_DI_STATUS + 16'(mps_pkg::N_DI_WORDS));
    d.di_word = 2'(d.base - mps_pkg::ADDR_DI_STATUS);
    d.is_pw = (d.base == mps_pkg::ADDR_PASSWORD);
    d.bad_grp = !d.is_di && (d.base[15:8] >= 8'(mps_pkg::N_GROUPS));
    d.bad_idx = !d.is_di && !d.bad_grp && (d.base[7:0] >= 8'(mps_pkg::N_INDEX));
    d.pidx = 8'(d.base[15:8] * 8'(mps_pkg::N_INDEX) + d.base[7:0]);
    return d;
  endfunction

  // Request fields taken from the received frame.
  wire [7:0] fn = rx_buf_q[1];
  wire [15:0] start_addr = {rx_buf_q[2], rx_buf_q[3]};
  wire [15:0] field2 = {rx_buf_q[4], rx_buf_q[5]};
  wire [7:0] nbytes = rx_buf_q[6];
  wire is_rd = (fn == mps_pkg::FN_READ);
  wire is_w1 = (fn == mps_pkg::FN_WRITE1);
  wire is_wn = (fn == mps_pkg::FN_WRITEN);
  wire [5:0] wn_len = 6'(7'd9 + {field2[5:0], 1'b0});
  mps_pkg::mps_dec_t start_dec;
  assign start_dec = decode(start_addr);

  // Header checks, in priority order, before any register is touched.
  wire [7:0] hdr_err =
    (crc_q != 16'h0000) ? mps_pkg::E_CRC :
    !(is_rd || is_w1 || is_wn) ? mps_pkg::E_CMD :
    ((is_rd || is_w1) && len_q != 6'h08) ? mps_pkg::E_CMD :
    ((is_rd || is_wn) && field2 == 16'h0000) ? mps_pkg::E_ZERO :
    (is_rd && field2 > 16'(mps_pkg::READ_MAX)) ? mps_pkg::E_GROUP :
    (is_wn && field2 > 16'(mps_pkg::WRITE_MAX)) ? mps_pkg::E_GROUP :
    (is_wn && (nbytes != {field2[6:0], 1'b0} || len_q != wn_len)) ? mps_pkg::E_CMD :
    (is_wn && start_dec.is_pw && field2 != 16'h0001) ? mps_pkg::E_PWMIX :
    mps_pkg::E_NONE;

  // Current register of the scan and its value.
  wire [15:0] cur_addr = start_addr + {12'h000, k_q};
  mps_pkg::mps_dec_t cur;
  assign cur = decode(cur_addr);
  wire [5:0] dat_idx = 6'(6'd7 + {1'b0, k_q, 1'b0});
  wire [15:0] cur_val = is_w1 ? field2 : {rx_buf_q[dat_idx], rx_buf_q[6'(dat_idx + 6'd1)]};
  wire cur_first = (k_q == 4'h0);
  wire cur_last = (k_q == n_q - 4'h1);
  wire cur_wr = !is_rd;
  wire pw_set = (i_user_password != 16'h0000);
  wire cur_sel = (cur.base[15:8] == mps_pkg::SELECT_GROUP) && (cur.base[7:0] >= 8'h01) &&
                 (cur.base[7:0] <= 8'(mps_pkg::N_TERMINALS));
  wire [15:0] cur_rdata = cur.is_di ? di_stat_q[cur.di_word] :
                          cur.is_pw ? 16'h0000 : prm_q[cur.pidx];

  // Per-register checks; 32-bit pairs sit at indices E (low) and F (high).
  wire [7:0] cur_err =
    cur.bad_grp ? mps_pkg::E_GROUP :
    cur.bad_idx ? mps_pkg::E_PARAM :
    (!cur.is_di && cur.base[7:0] == mps_pkg::WIDE_LO_INDEX && cur_last) ? mps_pkg::E_HALF :
    (!cur.is_di && cur.base[7:0] == mps_pkg::WIDE_LO_INDEX + 8'h01 && cur_first) ?
      mps_pkg::E_HALF :
    (cur_wr && i_drive_running && cur.base[15:8] == mps_pkg::LOCKED_GROUP) ?
      mps_pkg::E_LOCKED :
    (cur_wr && pw_set && !o_pw_unlocked && !cur.is_pw) ? mps_pkg::E_NOPW :
    (cur_wr && cur_sel && cur_val > mps_pkg::SELECT_MAX) ? mps_pkg::E_LIMIT :
    mps_pkg::E_NONE;
  wire pw_match = (cur_val == i_user_password);
  wire [7:0] pw_code = (pw_fail_q + 3'h1 >= mps_pkg::PW_FAIL_LIMIT) ?
                       mps_pkg::E_PWBAD5 : mps_pkg::E_PWBAD;

  // Reply byte selection: buffer, then CRC low, then CRC high.
  wire [7:0] next_tx = (sidx_q < tx_len_q) ? tx_buf_q[sidx_q] :
                       (sidx_q == tx_len_q) ? tcrc_q[7:0] : tcrc_q[15:8];
  wire tx_move = !o_tx_valid || i_tx_ready;
  wire tx_done = (sidx_q == 6'(tx_len_q + 6'd2));
  wire ms_tick = (tick_q == 32'(MS_CYCLES - 1));
  wire frame_ok = !ovf_q && len_q >= 6'h04 && rx_buf_q[0] == i_axis_addr;

  // Input function map: terminal selections, link enables and link status.
  wire [63:0] en_vec = {prm_q[mps_pkg::ENABLE_PIDX0 + 3], prm_q[mps_pkg::ENABLE_PIDX0 + 2],
                        prm_q[mps_pkg::ENABLE_PIDX0 + 1],
                        prm_q[mps_pkg::ENABLE_PIDX0][15:1], 1'b0};
  wire [63:0] st_vec = {di_stat_q[3], di_stat_q[2], di_stat_q[1],
                        di_stat_q[0][15:1], 1'b0};
  wire [63:0] term_vec;
  wire [63:0] clash_vec;
  assign term_vec[0] = 1'b0;
  assign clash_vec[0] = 1'b0;
  genvar f;
  genvar t;
  generate
    for (f = 1; f < 64; f++) begin : g_func
      wire [mps_pkg::N_TERMINALS-1:0] sel_hit;
      for (t = 0; t < mps_pkg::N_TERMINALS; t++) begin : g_term
        assign sel_hit[t] = (prm_q[mps_pkg::SEL_PIDX0 + t] == 16'(f));
      end
      assign clash_vec[f] = |sel_hit;
      assign term_vec[f] = |(sel_hit & pin_s2_q);
    end
  endgenerate
  wire [63:0] link_ok = en_vec & ~clash_vec;
  wire cfg_fault = |(en_vec & clash_vec);

  // Terminal synchroniser and the function outputs.
  always_ff @(posedge i_clk) begin
    pin_s1_q <= i_di_pins;
    pin_s2_q <= pin_s1_q;
    if (i_rst) begin
      o_di_func <= 64'h0;
      o_config_fault <= 1'b0;
    end else begin
      o_di_func <= term_vec | (link_ok & st_vec);
      o_config_fault <= cfg_fault;
    end
  end

  // Millisecond tick.
  always_ff @(posedge i_clk) begin
    if (i_rst || ms_tick) tick_q <= 32'h0;
    else tick_q <= tick_q + 32'h1;
  end

  // Frame engine: receive, check, scan, apply and send.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= mps_pkg::ST_RECV;
      len_q <= 6'h0;
      ovf_q <= 1'b0;
      crc_q <= mps_pkg::CRC_INIT;
      tcrc_q <= mps_pkg::CRC_INIT;
      tx_len_q <= 6'h0;
      sidx_q <= 6'h0;
      k_q <= 4'h0;
      n_q <= 4'h0;
      pw_fail_q <= 3'h0;
      o_pw_unlocked <= 1'b0;
      unlock_ms_q <= 16'h0;
      refresh_ms_q <= 16'h0;
      o_tx_valid <= 1'b0;
      o_tx_byte <= 8'h00;
      o_commit <= '0;
      for (int i = 0; i < mps_pkg::FRAME_MAX; i++) begin
        rx_buf_q[i] <= 8'h00;
        tx_buf_q[i] <= 8'h00;
      end
      for (int i = 0; i < mps_pkg::N_PARAMS; i++) begin
        prm_q[i] <= 16'h0000;
      end
      prm_q[mps_pkg::TIMEOUT_PIDX] <= mps_pkg::TIMEOUT_RST_MS;
      for (int i = 0; i < mps_pkg::N_DI_WORDS; i++) begin
        di_stat_q[i] <= 16'h0000;
      end
    end else begin
      o_commit.valid <= 1'b0;
      // Link status lapses when not refreshed in time.
      if (ms_tick && refresh_ms_q != 16'hffff) refresh_ms_q <= refresh_ms_q + 16'h1;
      if (refresh_ms_q >= prm_q[mps_pkg::TIMEOUT_PIDX]) begin
        for (int i = 0; i < mps_pkg::N_DI_WORDS; i++) begin
          di_stat_q[i] <= 16'h0000;
        end
      end
      // Password entry expires after a fixed time.
      if (ms_tick && o_pw_unlocked) unlock_ms_q <= unlock_ms_q + 16'h1;
      if (unlock_ms_q >= mps_pkg::PW_EXPIRE_MS) begin
        o_pw_unlocked <= 1'b0;
        unlock_ms_q <= 16'h0;
      end
      unique case (state_q)
        mps_pkg::ST_RECV: begin
          if (i_rx_valid) begin
            if (len_q < 6'(mps_pkg::FRAME_MAX)) begin
              rx_buf_q[len_q] <= i_rx_byte;
              len_q <= len_q + 6'h1;
              crc_q <= crc_step(crc_q, i_rx_byte);
            end else begin
              ovf_q <= 1'b1;
            end
          end else if (i_rx_gap && len_q != 6'h0) begin
            if (frame_ok) state_q <= mps_pkg::ST_CHECK;
            else begin
              len_q <= 6'h0;
              ovf_q <= 1'b0;
              crc_q <= mps_pkg::CRC_INIT;
            end
          end
        end
        mps_pkg::ST_CHECK: begin
          tx_buf_q[0] <= rx_buf_q[0];
          for (int i = 1; i < 6; i++) begin
            tx_buf_q[i] <= rx_buf_q[i];
          end
          k_q <= 4'h0;
          n_q <= is_w1 ? 4'h1 : field2[3:0];
          if (hdr_err != mps_pkg::E_NONE) begin
            tx_buf_q[1] <= fn | mps_pkg::FN_ERR_BIT;
            tx_buf_q[2] <= hdr_err;
            tx_len_q <= 6'h3;
            state_q <= mps_pkg::ST_SEND;
          end else begin
            if (is_rd) tx_buf_q[2] <= {field2[6:0], 1'b0};
            state_q <= mps_pkg::ST_SCAN;
          end
        end
        mps_pkg::ST_SCAN: begin
          if (cur_err != mps_pkg::E_NONE) begin
            tx_buf_q[1] <= fn | mps_pkg::FN_ERR_BIT;
            tx_buf_q[2] <= cur_err;
            tx_len_q <= 6'h3;
            state_q <= mps_pkg::ST_SEND;
          end else begin
            if (is_rd) begin
              tx_buf_q[6'(dat_idx - 6'd4)] <= cur_rdata[15:8];
              tx_buf_q[6'(dat_idx - 6'd3)] <= cur_rdata[7:0];
            end
            if (!cur_last) k_q <= k_q + 4'h1;
            else if (is_rd) begin
              tx_len_q <= 6'(6'd3 + {1'b0, n_q, 1'b0});
              state_q <= mps_pkg::ST_SEND;
            end else begin
              k_q <= 4'h0;
              state_q <= mps_pkg::ST_APPLY;
            end
          end
        end
        mps_pkg::ST_APPLY: begin
          if (cur.is_pw) begin
            if (pw_match) begin
              o_pw_unlocked <= 1'b1;
              unlock_ms_q <= 16'h0;
              pw_fail_q <= 3'h0;
            end else begin
              if (pw_fail_q < mps_pkg::PW_FAIL_LIMIT) pw_fail_q <= pw_fail_q + 3'h1;
              tx_buf_q[1] <= fn | mps_pkg::FN_ERR_BIT;
              tx_buf_q[2] <= pw_code;
            end
          end else if (cur.is_di) begin
            di_stat_q[cur.di_word] <= cur_val;
            refresh_ms_q <= 16'h0;
          end else begin
            prm_q[cur.pidx] <= cur_val;
            o_commit <= '{valid: 1'b1, eeprom: cur.eeprom, addr: cur.base, data: cur_val};
          end
          if (!cur_last) k_q <= k_q + 4'h1;
          else begin
            tx_len_q <= (cur.is_pw && !pw_match) ? 6'h3 : 6'h6;
            state_q <= mps_pkg::ST_SEND;
          end
        end
        mps_pkg::ST_SEND: begin
          if (tx_move) begin
            if (tx_done) begin
              o_tx_valid <= 1'b0;
              sidx_q <= 6'h0;
              len_q <= 6'h0;
              ovf_q <= 1'b0;
              crc_q <= mps_pkg::CRC_INIT;
              tcrc_q <= mps_pkg::CRC_INIT;
              state_q <= mps_pkg::ST_RECV;
            end else begin
              o_tx_valid <= 1'b1;
              o_tx_byte <= next_tx;
              if (sidx_q < tx_len_q) tcrc_q <= crc_step(tcrc_q, next_tx);
              sidx_q <= sidx_q + 6'h1;
            end
          end
        end
      endcase
    end
  end

  // Checks on the frame engine and the function map.
  chk_silent_recv: assert property (@(posedge i_clk) disable iff (i_rst)
    state_q == mps_pkg::ST_RECV |-> !o_tx_valid)
    else $error("Reply byte driven while receiving.");
  chk_foreign_drop: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == mps_pkg::ST_RECV && !i_rx_valid && i_rx_gap && len_q != 6'h0 &&
     rx_buf_q[0] != i_axis_addr) |=> state_q == mps_pkg::ST_RECV && len_q == 6'h0)
    else $error("Frame for another axis not dropped.");
  chk_len_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    len_q <= 6'(mps_pkg::FRAME_MAX))
    else $error("Receive length beyond frame limit.");
  chk_crc_reply: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == mps_pkg::ST_CHECK && crc_q != 16'h0000) |=>
      tx_buf_q[2] == mps_pkg::E_CRC && tx_len_q == 6'h3 && state_q == mps_pkg::ST_SEND)
    else $error("CRC failure not answered with code 04.");
  chk_zero_count: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == mps_pkg::ST_CHECK && crc_q == 16'h0000 && is_rd && len_q == 6'h08 &&
     field2 == 16'h0000) |=> tx_buf_q[2] == mps_pkg::E_ZERO)
    else $error("Zero count not answered with code 17.");
  chk_exc_func: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == mps_pkg::ST_CHECK && hdr_err != mps_pkg::E_NONE) |=>
      tx_buf_q[1] == ($past(fn) | mps_pkg::FN_ERR_BIT))
    else $error("Exception function code wrong.");
  chk_half_wide: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == mps_pkg::ST_SCAN && !cur.bad_grp && !cur.bad_idx && !cur.is_di &&
     cur.base[7:0] == mps_pkg::WIDE_LO_INDEX && cur_last) |=>
      tx_buf_q[2] == mps_pkg::E_HALF)
    else $error("Half access to a 32-bit parameter accepted.");
  chk_eeprom_commit: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == mps_pkg::ST_APPLY && !cur.is_pw && !cur.is_di) |=>
      o_commit.valid && o_commit.eeprom == $past(cur.eeprom))
    else $error("Parameter write not reported with its store.");
  chk_pw_lockout: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == mps_pkg::ST_APPLY && cur.is_pw && !pw_match &&
     pw_fail_q == mps_pkg::PW_FAIL_LIMIT - 3'h1) |=> tx_buf_q[2] == mps_pkg::E_PWBAD5)
    else $error("Fifth wrong password not answered with code 26.");
  chk_di_fault: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg_fault |=> o_config_fault && (o_di_func & $past(clash_vec & ~term_vec)) == 64'h0)
    else $error("Select clash not flagged or link control accepted.");
  chk_di_reserved: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_di_func[0])
    else $error("Reserved function bit asserted.");
  cov_read: cover property (@(posedge i_clk) disable iff (i_rst)
    state_q == mps_pkg::ST_SCAN && is_rd && cur_last && cur_err == mps_pkg::E_NONE);
  cov_write_multi: cover property (@(posedge i_clk) disable iff (i_rst)
    state_q == mps_pkg::ST_APPLY && is_wn && cur_last);
  cov_pw_ok: cover property (@(posedge i_clk) disable iff (i_rst)
    state_q == mps_pkg::ST_APPLY && cur.is_pw && pw_match);
  cov_link_di: cover property (@(posedge i_clk) disable iff (i_rst) |(link_ok & st_vec));

endmodule

// File: testbench/mps_host_model.sv
// Host side of the link: sends request frames as byte strobes and gathers the reply.
module mps_host_model (
  input wire logic i_clk,            // System clock.
  input wire logic i_tx_valid,       // Reply byte valid.
  input wire logic [7:0] i_tx_byte,  // Reply byte.
  output logic o_rx_valid,           // Request byte strobe.
  output logic [7:0] o_rx_byte,      // Request byte.
  output logic o_rx_gap,             // End of frame strobe.
  output logic o_tx_ready            // Reply byte taken.
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] mps_bq_t [$];
  mps_bq_t rp;
  // Lines are quiet until the first frame.
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
    o_rx_gap = 1'b0;
    o_tx_ready = 1'b0;
  end
  // Appends the reflected CRC-16, low byte first.
  function automatic mps_bq_t seal(input mps_bq_t f);
    logic [15:0] c;
    c = 16'hffff;
    foreach (f[i])
    begin
      c = c ^ {8'h00, f[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    return f;
  endfunction
  // One request and its reply; a slow host takes reply bytes every other cycle.
  task automatic xfer(input mps_bq_t f, input bit slow);
    int idle;
    rp = {};
    foreach (f[i])
    begin
      @(negedge i_clk) o_rx_valid = 1'b1;
      o_rx_byte = f[i];
      @(negedge i_clk) o_rx_valid = 1'b0;
      o_rx_byte = ~f[i];
    end
    @(negedge i_clk) o_rx_gap = 1'b1;
    @(negedge i_clk) o_rx_gap = 1'b0;
    idle = 0;
    while (idle < 40)
    begin
      @(negedge i_clk) o_tx_ready = slow ? ~o_tx_ready : 1'b1;
      @(posedge i_clk);
      if (i_tx_valid && o_tx_ready)
      begin
        rp.push_back(i_tx_byte);
        idle = 0;
      end
      else
        idle++;
    end
    // Ready drops one falling edge later, so it never changes twice in a time step.
    @(negedge i_clk) o_tx_ready = 1'b0;
  endtask
endmodule

// File: testbench/modbus_parameter_slave_test.sv
// Drives frames through the host model and compares every reply byte.
module modbus_parameter_slave_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] mps_bq_t [$];
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic run_q = 1'b0;
  logic [15:0] pw = 16'h0000;
  logic [7:0] pins = 8'h00;
  logic tx_valid, rx_valid, rx_gap, tx_ready, fault, unlocked;
  logic [7:0] tx_byte, rx_byte;
  logic [63:0] di_func;
  mps_pkg::mps_commit_t commit, cm;
  int error_cnt = 0;
  int total_checks = 0;
  always #5 i_clk = ~i_clk;
  // Keeps the last reported parameter write.
  always @(posedge i_clk) if (commit.valid) cm <= commit;
  mps_slave #(.MS_CYCLES(10)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_axis_addr(8'h01),
    .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .i_rx_gap(rx_gap), .i_tx_ready(tx_ready),
    .i_drive_running(run_q), .i_user_password(pw), .i_di_pins(pins), .o_tx_valid(tx_valid),
    .o_tx_byte(tx_byte), .o_commit(commit), .o_di_func(di_func), .o_config_fault(fault),
    .o_pw_unlocked(unlocked));
  mps_host_model host_u (.i_clk(i_clk), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte),
    .o_rx_valid(rx_valid), .o_rx_byte(rx_byte), .o_rx_gap(rx_gap), .o_tx_ready(tx_ready));
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic mps_bq_t fr(input logic [127:0] v, input int n);
    mps_bq_t q;
    for (int i = n - 1; i >= 0; i--) q.push_back(v[i*8 +: 8]);
    return q;
  endfunction
  // Mode 1 is a slow host, mode 2 spoils the CRC; an empty reply means none is expected.
  task automatic run(input logic [127:0] fv, input int fn, input logic [127:0] ev,
    input int en, input int mode);
    mps_bq_t g, e;
    g = host_u.seal(fr(fv, fn));
    e = en ? host_u.seal(fr(ev, en)) : fr(ev, 0);
    if (mode == 2) g[fn] = ~g[fn];
    host_u.xfer(g, mode == 1);
    chk("reply length", e.size(), host_u.rp.size());
    if (e.size() == host_u.rp.size()) foreach (e[i]) chk("reply byte", e[i], host_u.rp[i]);
  endtask
  task automatic ex(input logic [127:0] fv, input int fn, input logic [7:0] code);
    run(fv, fn, {fv[fn*8-1 -: 8], fv[fn*8-9 -: 8] | 8'h80, code}, 3, 0);
  endtask
  task automatic t_basic;
    run(48'h01_03_0401_0001, 6, 40'h01_03_02_0000, 5, 0);
    run(48'h01_06_0401_0005, 6, 48'h01_06_0401_0005, 6, 1);
    chk("commit", {1'b0, 32'h0401_0005}, {cm.eeprom, cm.addr, cm.data});
    run(48'h01_03_0401_0001, 6, 40'h01_03_02_0005, 5, 0);
    run(48'h01_06_e402_0007, 6, 48'h01_06_e402_0007, 6, 0);
    chk("commit", {1'b1, 32'h0402_0007}, {cm.eeprom, cm.addr, cm.data});
    run(88'h01_10_0201_0002_04_1234_5678, 11, 48'h01_10_0201_0002, 6, 0);
    run(48'h01_03_0201_0002, 6, 56'h01_03_04_1234_5678, 7, 1);
    run(48'h01_03_0000_0001, 6, 40'h01_03_02_0000, 5, 0);
    $display("basic access test done");
  endtask
  task automatic t_errors;
    ex(48'h01_05_0000_0001, 6, 8'h01);
    ex(48'h01_03_0401_0000, 6, 8'h11);
    run(48'h01_03_0401_0001, 6, 24'h01_83_04, 3, 2);
    ex(48'h01_06_040e_0001, 6, 8'h12);
    ex(48'h01_06_0401_0023, 6, 8'h13);
    ex(48'h01_03_0a00_0001, 6, 8'h10);
    ex(48'h01_03_0401_0010, 6, 8'h10);
    ex(88'h01_10_0201_0002_03_1234_5678, 11, 8'h01);
    ex(48'h01_03_0010_0001, 6, 8'h03);
    ex(88'h01_10_0000_0002_04_0001_0002, 11, 8'h18);
    run_q = 1'b1;
    ex(48'h01_06_0101_0001, 6, 8'h15);
    run_q = 1'b0;
    run(48'h02_03_0401_0001, 6, 0, 0, 0);
    $display("exception test done");
  endtask
  task automatic t_di;
    run(88'h01_10_0905_0002_04_0002_0001, 11, 48'h01_10_0905_0002, 6, 0);
    run(88'h01_10_3607_0002_04_0002_0001, 11, 48'h01_10_3607_0002, 6, 0);
    chk("active functions", 64'h0000_0000_0001_0002, di_func);
    chk("config fault", 1'b0, fault);
    run(48'h01_06_0401_0001, 6, 48'h01_06_0401_0001, 6, 0);
    repeat (3) @(negedge i_clk);
    chk("config fault", 1'b1, fault);
    pins = 8'h02;
    repeat (4) @(negedge i_clk);
    chk("active functions", 64'h0000_0000_0001_0080, di_func);
    run(48'h01_06_090b_0002, 6, 48'h01_06_090b_0002, 6, 0);
    chk("active functions", 64'h0000_0000_0000_0080, di_func);
    $display("link input test done");
  endtask
  task automatic t_password;
    pw = 16'h1234;
    ex(48'h01_06_0402_0001, 6, 8'h14);
    for (int i = 1; i <= 5; i++) ex(48'h01_06_0000_0001, 6, (i == 5) ? 8'h1a : 8'h19);
    chk("unlocked", 1'b0, unlocked);
    run(48'h01_06_0000_1234, 6, 48'h01_06_0000_1234, 6, 0);
    chk("unlocked", 1'b1, unlocked);
    $display("password test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence after four cycles of reset.
  initial
  begin
    repeat (4) @(posedge i_clk);
    @(negedge i_clk) i_rst = 1'b0;
    t_basic();
    t_errors();
    t_di();
    t_password();
    close_out();
  end
  // Cuts a hang short.
  initial
  begin
    #300us;
    error_cnt++;
    close_out();
  end
endmodule
